// [rtl/sfd_params.svh]
`ifndef SFD_PARAMS_SVH
`define SFD_PARAMS_SVH
// What this block does
// - Fetch runs through four stages (address, fetch, early decode, buffer) and every word passes all four.
// - Every generated fetch address is looked up in the branch cache.
// - On a branch cache miss the fetch address simply advances sequentially.
// - On a hit the next fetch address is the cached target; no fetch in flight is dropped.
// - Early decode turns each variable-length word into a fixed-length record with control bits.
// - The instruction buffer is first-in first-out and decouples fetch from execution.
// - One entry or a pair is taken from the buffer each cycle unless the buffer is empty or a hold is raised.
// - Each integer pipe has six ordered stages: decode, address calc, operand fetch, execute, result, write-back.
// - Per clock at most two may issue: two integer, or one integer and one float, or a branch in either slot.
// - A float instruction goes to the float unit once it has left the operand fetch stage.
// - Write-back holds integer store data from the primary pipe until memory signals ready, then releases it.
// - A control input turns off superscalar issue so only the primary pipe runs.
`define SFD_PC_RESET      32'h0000_0000
`define SFD_PC_STEP       32'h0000_0004
`define SFD_BC_IDX_LSB    2
`define SFD_CLS_INT       2'h0
`define SFD_CLS_FP        2'h1
`define SFD_CLS_BR        2'h2
`define SFD_CLS_UNIMP     2'h3
`define SFD_OP_MSB        31
`define SFD_OP_LSB        30
`define SFD_STORE_BIT     29
`endif

// [rtl/sfd_pkg.sv]
package sfd_pkg;
    typedef struct packed {
        logic        valid;
        logic [1:0]  cls;
        logic        store;
        logic [31:0] pc;
        logic [31:0] word;
    } sfd_dec_s;
    typedef struct packed {
        logic        valid;
        logic [31:0] pc;
        logic [31:0] word;
    } sfd_raw_s;
    typedef enum logic [1:0] {
        SFD_WB_IDLE = 2'b00,
        SFD_WB_WAIT = 2'b01
    } sfd_wb_e;
endpackage

// [rtl/sfd_top.sv]
`include "sfd_params.svh"
module sfd_top import sfd_pkg::*; #(
    parameter int BC_ENTRIES = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [31:0]      icache_data,
    input  wire logic             icache_valid,
    input  wire logic             bc_wr,
    input  wire logic [31:0]      bc_wr_pc,
    input  wire logic [31:0]      bc_wr_target,
    input  wire logic             exec_hold,
    input  wire logic             superscalar_off,
    input  wire logic             mem_ready,
    input  wire logic             fpu_ready,
    output logic     [31:0]       fetch_addr,
    output logic                  fetch_req,
    output logic                  fpu_valid,
    output logic     [31:0]       fpu_word,
    output logic                  wb_valid,
    output logic     [31:0]       wb_data,
    output logic                  unimp_exc,
    output logic                  issue_primary,
    output logic                  issue_secondary,
    output logic                  issue_branch
);
    localparam int IW = $clog2(BC_ENTRIES);
    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [1:0] hold_sync_ff, ss_sync_ff, mrdy_sync_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_sync_ff <= 2'h0;
            ss_sync_ff   <= 2'h0;
            mrdy_sync_ff <= 2'h0;
        end else begin
            hold_sync_ff <= {hold_sync_ff[0], exec_hold};
            ss_sync_ff   <= {ss_sync_ff[0], superscalar_off};
            mrdy_sync_ff <= {mrdy_sync_ff[0], mem_ready};
        end
    end
    wire hold  = hold_sync_ff[1];
    wire ssoff = ss_sync_ff[1];
    wire mrdy  = mrdy_sync_ff[1];

    function automatic logic [1:0] classify(input logic [31:0] w);
        classify = w[`SFD_OP_MSB:`SFD_OP_LSB];
    endfunction
    function automatic logic [IW-1:0] bc_idx(input logic [31:0] a);
        bc_idx = a[`SFD_BC_IDX_LSB +: IW];
    endfunction

    // ****************************************
    // Branch cache
    // ****************************************
    logic [31:0] bc_tag_ff [BC_ENTRIES];
    logic [31:0] bc_tgt_ff [BC_ENTRIES];
    logic [BC_ENTRIES-1:0] bc_val_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) bc_val_ff <= '0;
        else if (bc_wr) bc_val_ff[bc_idx(bc_wr_pc)] <= 1'b1;
    end
    always_ff @(posedge clk) begin
        if (bc_wr) begin
            bc_tag_ff[bc_idx(bc_wr_pc)] <= bc_wr_pc;
            bc_tgt_ff[bc_idx(bc_wr_pc)] <= bc_wr_target;
        end
    end

    // ****************************************
    // Fetch pipeline: address, fetch, decode, buffer
    // ****************************************
    logic [31:0] pc_ff;
    sfd_raw_s    fet_ff;
    sfd_dec_s    dec_ff;
    logic        buf_ready;
    wire stall_front = dec_ff.valid && !buf_ready;
    // Lookup on each generated address; hit must match the stored address
    wire bc_hit = bc_val_ff[bc_idx(pc_ff)] &&
                  (bc_tag_ff[bc_idx(pc_ff)] == pc_ff);
    wire [31:0] nxt_pc = bc_hit ? bc_tgt_ff[bc_idx(pc_ff)]
                                : pc_ff + `SFD_PC_STEP;
    assign fetch_addr = pc_ff;
    assign fetch_req  = !stall_front;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) pc_ff <= `SFD_PC_RESET;
        else if (!stall_front && icache_valid) pc_ff <= nxt_pc;
    end
    // Fetch stage; lookup is on the address itself, so no word past a taken branch is fetched
    always_ff @(posedge clk or posedge rst) begin
        if (rst) fet_ff <= '0;
        else if (!stall_front) begin
            fet_ff.valid <= icache_valid;
            fet_ff.pc    <= pc_ff;
            fet_ff.word  <= icache_data;
        end
    end
    // Early decode into fixed record
    always_ff @(posedge clk or posedge rst) begin
        if (rst) dec_ff <= '0;
        else if (!stall_front) begin
            dec_ff.valid <= fet_ff.valid;
            dec_ff.cls   <= classify(fet_ff.word);
            dec_ff.store <= fet_ff.word[`SFD_STORE_BIT];
            dec_ff.pc    <= fet_ff.pc;
            dec_ff.word  <= fet_ff.word;
        end
    end

    // ****************************************
    // Instruction buffer: two entries
    // ****************************************
    sfd_dec_s buf_ff [2];
    logic [1:0] cnt_ff;
    logic       rd_ff;
    logic       wr_ff;
    logic [1:0] take;
    assign buf_ready = (cnt_ff != 2'h2);
    wire push = dec_ff.valid && buf_ready;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= 2'h0;
            rd_ff  <= 1'b0;
            wr_ff  <= 1'b0;
        end else begin
            cnt_ff <= cnt_ff + {1'b0, push} - take;
            wr_ff  <= wr_ff ^ push;
            rd_ff  <= rd_ff ^ take[0];
        end
    end
    always_ff @(posedge clk) begin
        if (push) buf_ff[wr_ff] <= dec_ff;
    end
    sfd_dec_s head0, head1;
    assign head0 = buf_ff[rd_ff];
    assign head1 = buf_ff[~rd_ff];

    // ****************************************
    // Issue
    // ****************************************
    logic wb_busy;
    logic fpu_busy;
    wire  pipe_hold = hold || wb_busy || fpu_busy;
    logic dual_ok;
    always_comb begin
        // Pair any two except float+float or branch+branch; a branch may join either slot
        dual_ok = !ssoff && cnt_ff == 2'h2 &&
                  !(head0.cls == `SFD_CLS_FP && head1.cls == `SFD_CLS_FP) &&
                  !(head0.cls == `SFD_CLS_BR && head1.cls == `SFD_CLS_BR);
        if (pipe_hold || cnt_ff == 2'h0) take = 2'h0;
        else if (dual_ok) take = 2'h2;
        else take = 2'h1;
    end

    // ****************************************
    // Integer pipes: six stages each
    // ****************************************
    sfd_dec_s p0_ff [6];
    sfd_dec_s p1_ff [6];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 6; i++) begin
                p0_ff[i] <= '0;
                p1_ff[i] <= '0;
            end
        end else if (!pipe_hold) begin
            p0_ff[0] <= (take != 2'h0) ? head0 : '0;
            p1_ff[0] <= (take == 2'h2) ? head1 : '0;
            for (int i = 1; i < 6; i++) begin
                p0_ff[i] <= p0_ff[i-1];
                p1_ff[i] <= p1_ff[i-1];
            end
            // Float ops leave the integer pipe after operand fetch
            if (p0_ff[2].cls == `SFD_CLS_FP) p0_ff[3] <= '0;
            if (p1_ff[2].cls == `SFD_CLS_FP) p1_ff[3] <= '0;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            issue_primary   <= 1'b0;
            issue_secondary <= 1'b0;
            issue_branch    <= 1'b0;
            unimp_exc       <= 1'b0;
        end else begin
            issue_primary   <= take != 2'h0;
            issue_secondary <= take == 2'h2;
            issue_branch    <= (take != 2'h0 && head0.cls == `SFD_CLS_BR) ||
                               (take == 2'h2 && head1.cls == `SFD_CLS_BR);
            unimp_exc       <= !pipe_hold &&
                               ((p0_ff[0].valid && p0_ff[0].cls == `SFD_CLS_UNIMP) ||
                                (p1_ff[0].valid && p1_ff[0].cls == `SFD_CLS_UNIMP));
        end
    end

    // ****************************************
    // Float hand-off; one slot, primary first
    // ****************************************
    // A second float op waits in operand fetch until the first is taken, so none is lost
    assign fpu_busy = fpu_valid && !fpu_ready &&
                      ((p0_ff[2].valid && p0_ff[2].cls == `SFD_CLS_FP) ||
                       (p1_ff[2].valid && p1_ff[2].cls == `SFD_CLS_FP));
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fpu_valid <= 1'b0;
            fpu_word  <= 32'h0000_0000;
        end else if (!pipe_hold && p0_ff[2].valid && p0_ff[2].cls == `SFD_CLS_FP) begin
            fpu_valid <= 1'b1;
            fpu_word  <= p0_ff[2].word;
        end else if (!pipe_hold && p1_ff[2].valid && p1_ff[2].cls == `SFD_CLS_FP) begin
            fpu_valid <= 1'b1;
            fpu_word  <= p1_ff[2].word;
        end else if (fpu_ready) begin
            fpu_valid <= 1'b0;
        end
    end

    // ****************************************
    // Write-back store hold
    // ****************************************
    sfd_wb_e wb_st_ff;
    // Stores from the secondary pipe are not held; a limitation of this simple write path
    // Captured only as the store leaves the pipe, so a frozen pipe never stores twice
    wire wb_new = !pipe_hold && p0_ff[5].valid && p0_ff[5].store &&
                  p0_ff[5].cls == `SFD_CLS_INT;
    assign wb_busy = (wb_st_ff == SFD_WB_WAIT) && !mrdy;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_st_ff <= SFD_WB_IDLE;
            wb_valid <= 1'b0;
            wb_data  <= 32'h0000_0000;
        end else begin
            case (wb_st_ff)
                SFD_WB_IDLE: begin
                    if (wb_new) begin
                        wb_st_ff <= SFD_WB_WAIT;
                        wb_valid <= 1'b1;
                        wb_data  <= p0_ff[5].word;
                    end
                end
                SFD_WB_WAIT: begin
                    if (mrdy) begin
                        wb_st_ff <= SFD_WB_IDLE;
                        wb_valid <= 1'b0;
                    end
                end
                default: wb_st_ff <= SFD_WB_IDLE;
            endcase
        end
    end
endmodule

// [tb/sfd_assertions.sv]
`include "sfd_params.svh"
module sfd_assertions import sfd_pkg::*; #(
    parameter int BC_ENTRIES = 16
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [31:0] icache_data,
    input wire logic        icache_valid,
    input wire logic        bc_wr,
    input wire logic        exec_hold,
    input wire logic        superscalar_off,
    input wire logic        mem_ready,
    input wire logic        fpu_ready,
    input wire logic [31:0] fetch_addr,
    input wire logic        fetch_req,
    input wire logic        fpu_valid,
    input wire logic [31:0] fpu_word,
    input wire logic        wb_valid,
    input wire logic [31:0] wb_data,
    input wire logic        unimp_exc,
    input wire logic        issue_primary,
    input wire logic        issue_secondary
);
    // ****
    // Step check only holds until the first branch entry since reset exists
    // ****
    logic bc_used_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) bc_used_ff <= 1'b0;
        else if (bc_wr) bc_used_ff <= 1'b1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_seq_fetch: assert property (
        !bc_used_ff && fetch_req && icache_valid |=> fetch_addr == $past(fetch_addr) + 32'h4)
        else $error("fetch address did not step");
    a_hold_stall: assert property (
        exec_hold [*5] |-> !issue_primary && !issue_secondary)
        else $error("issue during hold");
    a_single_issue: assert property (
        superscalar_off [*5] |-> !issue_secondary)
        else $error("second pipe issued");
    a_pair_order: assert property (
        issue_secondary |-> issue_primary)
        else $error("second issue without first");
    a_fpu_stand: assert property (
        fpu_valid && !fpu_ready |=> fpu_valid && $stable(fpu_word))
        else $error("float word dropped");
    a_fpu_class: assert property (
        fpu_valid |-> fpu_word[31:30] == 2'h1)
        else $error("non float word to float unit");
    a_wb_stand: assert property (
        wb_valid && !mem_ready && !$past(mem_ready) && !$past(mem_ready, 2)
        |=> wb_valid && $stable(wb_data))
        else $error("store released early");
    a_exc_raise: assert property (
        fetch_req && icache_valid && icache_data[31:30] == 2'h3 && !exec_hold
        |-> ##[1:12] unimp_exc)
        else $error("no trap for unimplemented word");
endmodule

// [tb/sfd_mem_model.sv]
module sfd_mem_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        slow,
    input  wire logic [31:0] fetch_addr,
    input  wire logic        fpu_valid,
    output logic      [31:0] icache_data,
    output logic             icache_valid,
    output logic             fpu_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [32];
    logic [1:0]  cnt;
    logic        tg;
    // ****
    // Idle data is inverted so a stale word never passes for a fetch
    // ****
    assign icache_valid = !slow || tg;
    assign icache_data = icache_valid ? mem[fetch_addr[6:2]] : ~mem[fetch_addr[6:2]];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 2'h0;
            fpu_ready <= 1'b0;
            tg <= 1'b0;
        end else begin
            tg <= !tg;
            cnt <= (fpu_ready || !fpu_valid) ? 2'h0 : cnt + 2'h1;
            fpu_ready <= fpu_valid && !fpu_ready && (cnt >= (slow ? 2'h3 : 2'h0));
        end
    end
endmodule

// [tb/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, bc_wr, exec_hold, superscalar_off, mem_ready, slow, icache_valid;
    logic        fetch_req, fpu_valid, fpu_ready, wb_valid, unimp_exc, wv;
    logic        issue_primary, issue_secondary, issue_branch;
    logic [31:0] bc_wr_pc, bc_wr_target, icache_data, fetch_addr, fpu_word, wb_data, w0, wd;
    int          miscompares, tests_run, np, ns, nb, nx, bad, hit;
    logic [31:0] fq[$];
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    sfd_top DUT (
        .clk             (clk),
        .rst             (rst),
        .icache_data     (icache_data),
        .icache_valid    (icache_valid),
        .bc_wr           (bc_wr),
        .bc_wr_pc        (bc_wr_pc),
        .bc_wr_target    (bc_wr_target),
        .exec_hold       (exec_hold),
        .superscalar_off (superscalar_off),
        .mem_ready       (mem_ready),
        .fpu_ready       (fpu_ready),
        .fetch_addr      (fetch_addr),
        .fetch_req       (fetch_req),
        .fpu_valid       (fpu_valid),
        .fpu_word        (fpu_word),
        .wb_valid        (wb_valid),
        .wb_data         (wb_data),
        .unimp_exc       (unimp_exc),
        .issue_primary   (issue_primary),
        .issue_secondary (issue_secondary),
        .issue_branch    (issue_branch)
    );
    sfd_mem_model PM (
        .clk          (clk),
        .rst          (rst),
        .slow         (slow),
        .fetch_addr   (fetch_addr),
        .fpu_valid    (fpu_valid),
        .icache_data  (icache_data),
        .icache_valid (icache_valid),
        .fpu_ready    (fpu_ready)
    );
    // ****
    // Shared helpers
    // ****
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic run(input int c);
        {np, ns, nb, nx, bad, hit} = '0;
        fq.delete();
        repeat (c) begin
            @(negedge clk);
            np += issue_primary;
            ns += issue_secondary;
            nb += issue_branch;
            nx += unimp_exc;
            bad += (fetch_addr >= 32'h20 && fetch_addr < 32'h40);
            hit += (fetch_addr == 32'h40);
            wv = wb_valid;
            wd = wb_data;
            if (fpu_valid && fpu_ready) fq.push_back(fpu_word);
        end
        // Return on a rising edge so that the next drive lands on the edge
        @(posedge clk);
    endtask
    task automatic restart();
        for (int i = 0; i < 32; i++) PM.mem[i] = 32'h0;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_pipe();
        restart();
        run(4);
        chk(np, 0, "issue too early");
        run(1);
        chk(np, 1, "first issue late");
        run(20);
        chk(np, 20, "buffer not drained each cycle");
        exec_hold <= 1'b1;
        run(5);
        run(10);
        chk(np + ns, 0, "issue under hold");
        exec_hold <= 1'b0;
        run(10);
        chk(np > 0 && ns > 0, 1, "no dual issue");
        // Fill the buffer again so that a pair would be possible
        superscalar_off <= 1'b1;
        exec_hold <= 1'b1;
        run(15);
        exec_hold <= 1'b0;
        run(20);
        chk(ns, 0, "second pipe busy");
        chk(np > 0, 1, "first pipe idle");
        superscalar_off <= 1'b0;
        $display("pipe done");
    endtask
    task automatic t_fp();
        slow <= 1'b1;
        restart();
        PM.mem[0] = 32'h4000_00A1;
        PM.mem[1] = 32'h4000_00B2;
        run(40);
        chk(fq.size() >= 2, 1, "float handoff");
        chk(fq[0], 32'h4000_00A1, "float order 0");
        chk(fq[1], 32'h4000_00B2, "float order 1");
        slow <= 1'b0;
        $display("float done");
    endtask
    task automatic t_store();
        superscalar_off <= 1'b1;
        mem_ready <= 1'b0;
        restart();
        PM.mem[0] = 32'h2000_0055;
        run(30);
        w0 = wd;
        chk(wv, 1'b1, "store missing");
        chk(wd, 32'h2000_0055, "store data wrong");
        run(10);
        chk(wv, 1'b1, "store dropped early");
        chk(wd, w0, "store data moved");
        mem_ready <= 1'b1;
        run(6);
        chk(wv, 1'b0, "store not released");
        superscalar_off <= 1'b0;
        restart();
        PM.mem[2] = 32'hC000_0000;
        run(20);
        chk(nx, 1, "no single trap");
        $display("store and trap done");
    endtask
    task automatic t_branch();
        restart();
        PM.mem[4] = 32'h8000_0000;
        bc_wr <= 1'b1;
        bc_wr_pc <= 32'h10;
        bc_wr_target <= 32'h40;
        @(posedge clk);
        bc_wr <= 1'b0;
        run(20);
        chk(hit > 0, 1, "no redirect");
        chk(bad, 0, "stale stream kept");
        chk(nb > 0, 1, "branch not issued");
        $display("branch done");
    endtask
    initial begin
        {bc_wr, exec_hold, superscalar_off, slow} = '0;
        mem_ready = 1'b1;
        {bc_wr_pc, bc_wr_target} = '0;
        rst = 1'b1;
        t_pipe();
        t_fp();
        t_store();
        t_branch();
        end_of_test();
    end
endmodule
bind sfd_top sfd_assertions #(.BC_ENTRIES(BC_ENTRIES)) u_chk (
    .clk             (clk),
    .rst             (rst),
    .icache_data     (icache_data),
    .icache_valid    (icache_valid),
    .bc_wr           (bc_wr),
    .exec_hold       (exec_hold),
    .superscalar_off (superscalar_off),
    .mem_ready       (mem_ready),
    .fpu_ready       (fpu_ready),
    .fetch_addr      (fetch_addr),
    .fetch_req       (fetch_req),
    .fpu_valid       (fpu_valid),
    .fpu_word        (fpu_word),
    .wb_valid        (wb_valid),
    .wb_data         (wb_data),
    .unimp_exc       (unimp_exc),
    .issue_primary   (issue_primary),
    .issue_secondary (issue_secondary)
);
